// ==== logic/pointer_driven_serial_port.sv ====
// Serial port that receives into and transmits from memory via a pointer
//
// Functional notes
// - Both lines idle high, CMOS sense
// - Receive baud 110 up to 4800/9600
// - High performance variant receives up to 38400
// - Receive stops after programmed byte count
// - Received bytes go straight into memory
// - Receive aborts when 10 ms tick timeout expires
// - Timeout starts with the command itself
// - Timeout programmable 0.01 to 655.35 seconds
// - Eight data bits, no parity, one stop
// - Pointer advances per received byte
// - Receive byte count limited by the 32 bit cmd_count, so at most 4294967295
// - Start bit level sensed unless high performance
// - Slow crystal receive limited to 4800 baud
// - Transmit baud 110-9600, 38400 high performance
// - Transmit count bytes from pointer address
// - Pointer updated once transmission completes
// - Transmit cannot be aborted once started
// - Configuration bit 4 reroutes transmit pin
// - Reroute bit cleared at power up
`timescale 1ns/1ps
`include "serial_port_consts.svh"
module pointer_driven_serial_port #(
    parameter int ADDR_W = 10,
    parameter bit HIGH_PERF = 1'b0,
    parameter logic [15:0] RX_BAUD_MAX = `RX_BAUD_MAX_FAST,
    parameter int TICK_CYCLES = `CLK_HZ / `MS_PER_S * `TICK_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_transmit,
    input wire logic [15:0] cmd_baud,
    input wire logic [31:0] cmd_count,
    input wire logic [ADDR_W-1:0] cmd_pointer,
    input wire logic [15:0] cmd_timeout,
    // Status
    output logic busy,
    output logic done,
    output logic done_timeout,
    output logic cmd_error,
    output logic [ADDR_W-1:0] done_pointer,
    // Configuration byte
    input wire logic config_we,
    input wire logic [7:0] config_data,
    output logic [7:0] config_byte,
    // Serial lines
    input wire logic rxd,
    output logic txd_main,
    output logic txd_alt,
    // Host access to the data memory while idle
    input wire logic host_we,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata
);
    // ========================================================
    // Elaboration checks
    initial begin
        if (ADDR_W < 1 || ADDR_W > 24) begin
            $error("ADDR_W out of range");
        end
        if (RX_BAUD_MAX < `BAUD_MIN || RX_BAUD_MAX > `RX_BAUD_MAX_FAST) begin
            $error("RX_BAUD_MAX out of range");
        end
        if (TICK_CYCLES < 2 || TICK_CYCLES > 1048575) begin
            $error("TICK_CYCLES out of range");
        end
    end

    localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);
    // High performance variant raises both limits
    localparam logic [15:0] RX_MAX = HIGH_PERF ? `BAUD_MAX_HP : RX_BAUD_MAX;
    localparam logic [15:0] TX_MAX = HIGH_PERF ? `BAUD_MAX_HP
                                               : `TX_BAUD_MAX_STD;

    // Cycles per bit, rounded down; 40 MHz keeps the error small
    function automatic logic [19:0] bit_period(input logic [15:0] baud);
        logic [31:0] q;
        q = 32'(`CLK_HZ) / {16'h0000, baud};
        return q[19:0];
    endfunction : bit_period

    // ========================================================
    // Input synchroniser; the first stage feeds only the second
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic rx_prev_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx_meta_reg <= `LINE_IDLE;
            rx_sync_reg <= `LINE_IDLE;
            rx_prev_reg <= `LINE_IDLE;
        end else begin
            rx_meta_reg <= rxd;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    // ========================================================
    // Configuration byte, cleared at power up so software rewrites it
    logic [7:0] config_reg;
    logic [7:0] config_next;

    always_comb begin
        config_next = config_reg;
        if (config_we) begin
            config_next = config_data;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            config_reg <= `CFG_RESET;
        end else begin
            config_reg <= config_next;
        end
    end

    // ========================================================
    // Sequencer state
    serial_port_pkg::state_type state_reg, state_next;
    logic [19:0] period_reg, period_next;
    logic [19:0] timer_reg, timer_next;
    logic [19:0] tick_reg, tick_next;
    logic [16:0] ticks_left_reg, ticks_left_next;
    logic [31:0] remain_reg, remain_next;
    logic [ADDR_W-1:0] ptr_reg, ptr_next;
    logic [ADDR_W-1:0] walk_reg, walk_next;
    logic [9:0] shift_reg, shift_next;
    logic [3:0] bits_reg, bits_next;
    logic line_reg, line_next;
    logic done_reg, done_next;
    logic tmo_reg, tmo_next;
    logic err_reg, err_next;
    logic txd_main_reg, txd_main_next;
    logic txd_alt_reg, txd_alt_next;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic start_seen;
    logic tick;
    logic [15:0] baud_max;

    // Start bit: level sensed on the standard variant, edge on the other
    assign start_seen = HIGH_PERF ? (rx_prev_reg && !rx_sync_reg)
                                  : !rx_sync_reg;
    assign tick = (tick_reg == TICK_LAST);
    assign baud_max = cmd_transmit ? TX_MAX : RX_MAX;

    // Next state of the receive and transmit sequencer
    always_comb begin
        state_next = state_reg;
        period_next = period_reg;
        timer_next = timer_reg;
        tick_next = tick ? 20'h0 : tick_reg + 20'h1;
        ticks_left_next = ticks_left_reg;
        remain_next = remain_reg;
        ptr_next = ptr_reg;
        walk_next = walk_reg;
        shift_next = shift_reg;
        bits_next = bits_reg;
        line_next = line_reg;
        done_next = 1'b0;
        tmo_next = tmo_reg;
        err_next = 1'b0;
        mem_we = 1'b0;
        mem_addr = host_addr;
        mem_wdata = host_wdata;
        if (timer_reg != 20'h0) begin
            timer_next = timer_reg - 20'h1;
        end
        case (state_reg)
            serial_port_pkg::st_idle: begin
                mem_we = host_we;
                if (cmd_valid) begin
                    if (cmd_baud < `BAUD_MIN || cmd_baud > baud_max) begin
                        err_next = 1'b1;
                    end else begin
                        period_next = bit_period(cmd_baud);
                        remain_next = cmd_count;
                        ptr_next = cmd_pointer;
                        walk_next = cmd_pointer;
                        tmo_next = 1'b0;
                        tick_next = 20'h0;
                        // Zero would mean no wait; serve it as one tick
                        ticks_left_next = (cmd_timeout == 16'h0000) ?
                            17'h1 : {1'b0, cmd_timeout};
                        if (cmd_count == 32'h0) begin
                            state_next = serial_port_pkg::st_done;
                        end else if (cmd_transmit) begin
                            state_next = serial_port_pkg::st_tx_fetch;
                        end else begin
                            state_next = serial_port_pkg::st_rx_hunt;
                        end
                    end
                end
            end
            serial_port_pkg::st_rx_hunt: begin
                if (start_seen) begin
                    // Land in the middle of the first data bit
                    timer_next = period_reg + {1'b0, period_reg[19:1]}
                                 - 20'h00002;
                    bits_next = 4'h0;
                    state_next = serial_port_pkg::st_rx_bits;
                end
            end
            serial_port_pkg::st_rx_bits: begin
                if (timer_reg == 20'h00000) begin
                    shift_next = {2'b00, rx_sync_reg, shift_reg[7:1]};
                    bits_next = bits_reg + 4'h1;
                    timer_next = period_reg - 20'h00001;
                    if (bits_reg == `DATA_BITS - 4'h1) begin
                        state_next = serial_port_pkg::st_rx_stop;
                    end
                end
            end
            serial_port_pkg::st_rx_stop: begin
                // Stop bit is not checked, so a held low line gives zeros
                if (timer_reg == 20'h00000) begin
                    mem_we = 1'b1;
                    mem_addr = ptr_reg;
                    mem_wdata = shift_reg[7:0];
                    ptr_next = ptr_reg + 1'b1;
                    remain_next = remain_reg - 32'h00000001;
                    if (remain_reg == 32'h00000001) begin
                        state_next = serial_port_pkg::st_done;
                    end else begin
                        state_next = serial_port_pkg::st_rx_hunt;
                    end
                end
            end
            serial_port_pkg::st_tx_fetch: begin
                mem_addr = walk_reg;
                state_next = serial_port_pkg::st_tx_load;
            end
            serial_port_pkg::st_tx_load: begin
                shift_next = {`LINE_IDLE, mem_rdata, 1'b0};
                bits_next = `FRAME_BITS;
                timer_next = period_reg - 20'h00001;
                line_next = 1'b0;
                state_next = serial_port_pkg::st_tx_bits;
            end
            serial_port_pkg::st_tx_bits: begin
                // No abort input reaches this state
                if (timer_reg == 20'h00000) begin
                    shift_next = {`LINE_IDLE, shift_reg[9:1]};
                    bits_next = bits_reg - 4'h1;
                    timer_next = period_reg - 20'h00001;
                    line_next = shift_reg[1];
                    if (bits_reg == 4'h1) begin
                        line_next = `LINE_IDLE;
                        walk_next = walk_reg + 1'b1;
                        remain_next = remain_reg - 32'h00000001;
                        if (remain_reg == 32'h00000001) begin
                            ptr_next = walk_reg + 1'b1;
                            state_next = serial_port_pkg::st_done;
                        end else begin
                            state_next = serial_port_pkg::st_tx_fetch;
                        end
                    end
                end
            end
            serial_port_pkg::st_done: begin
                done_next = 1'b1;
                state_next = serial_port_pkg::st_idle;
            end
            default: begin
                state_next = serial_port_pkg::st_idle;
            end
        endcase
        // Timeout guards receive only; a byte finishing this cycle is kept
        if ((state_reg == serial_port_pkg::st_rx_hunt ||
             state_reg == serial_port_pkg::st_rx_bits ||
             (state_reg == serial_port_pkg::st_rx_stop && !mem_we)) &&
            tick) begin
            ticks_left_next = ticks_left_reg - 17'h1;
            if (ticks_left_reg == 17'h1) begin
                tmo_next = 1'b1;
                state_next = serial_port_pkg::st_done;
            end
        end
        // Reroute moves the data to the alternate pin; the other idles
        txd_main_next = config_reg[`CFG_TX_REROUTE_BIT] ? `LINE_IDLE
                                                        : line_next;
        txd_alt_next = config_reg[`CFG_TX_REROUTE_BIT] ? line_next
                                                       : `LINE_IDLE;
    end

    // Register the sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= serial_port_pkg::st_idle;
            period_reg <= 20'h0;
            timer_reg <= 20'h0;
            tick_reg <= 20'h0;
            ticks_left_reg <= 17'h0;
            remain_reg <= 32'h0;
            ptr_reg <= '0;
            walk_reg <= '0;
            shift_reg <= 10'h000;
            bits_reg <= 4'h0;
            line_reg <= `LINE_IDLE;
            done_reg <= 1'b0;
            tmo_reg <= 1'b0;
            err_reg <= 1'b0;
            txd_main_reg <= `LINE_IDLE;
            txd_alt_reg <= `LINE_IDLE;
        end else begin
            state_reg <= state_next;
            period_reg <= period_next;
            timer_reg <= timer_next;
            tick_reg <= tick_next;
            ticks_left_reg <= ticks_left_next;
            remain_reg <= remain_next;
            ptr_reg <= ptr_next;
            walk_reg <= walk_next;
            shift_reg <= shift_next;
            bits_reg <= bits_next;
            line_reg <= line_next;
            done_reg <= done_next;
            tmo_reg <= tmo_next;
            err_reg <= err_next;
            txd_main_reg <= txd_main_next;
            txd_alt_reg <= txd_alt_next;
        end
    end

    // ========================================================
    // Data memory, shared between host and sequencer
    serial_port_memory #(
        .DATA_W(8),
        .ADDR_W(ADDR_W)
    ) data_memory (
        .clk(mclk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ========================================================
    // Outputs
    assign cmd_ready = (state_reg == serial_port_pkg::st_idle);
    assign busy = !cmd_ready;
    assign done = done_reg;
    assign done_timeout = tmo_reg;
    assign cmd_error = err_reg;
    assign done_pointer = ptr_reg;
    assign config_byte = config_reg;
    assign txd_main = txd_main_reg;
    assign txd_alt = txd_alt_reg;
    assign host_rdata = mem_rdata;
endmodule : pointer_driven_serial_port

// ==== logic/serial_port_consts.svh ====
// Constants for the pointer driven serial port
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
// ============================================================
// Clock and timing
`define CLK_HZ 40000000
`define TICK_MS 10
`define MS_PER_S 1000
// ============================================================
// Baud limits
`define BAUD_MIN 16'h006e
`define RX_BAUD_MAX_SLOW 16'h12c0
`define RX_BAUD_MAX_FAST 16'h2580
`define TX_BAUD_MAX_STD 16'h2580
`define BAUD_MAX_HP 16'h9600
// ============================================================
// Character frame: start, eight data, one stop
`define DATA_BITS 4'h8
`define FRAME_BITS 4'ha
`define LINE_IDLE 1'b1
// ============================================================
// Configuration byte
`define CFG_RESET 8'h00
`define CFG_TX_REROUTE_BIT 4
`endif

// ==== logic/serial_port_pkg.sv ====
// Types shared by the pointer driven serial port
package serial_port_pkg;
    // Sequencer states for receive and transmit operations
    typedef enum logic [2:0] {
        st_idle,
        st_rx_hunt,
        st_rx_bits,
        st_rx_stop,
        st_tx_fetch,
        st_tx_load,
        st_tx_bits,
        st_done
    } state_type;
endpackage : serial_port_pkg

// ==== logic/serial_port_memory.sv ====
// Single port byte memory with registered read data
`timescale 1ns/1ps
module serial_port_memory #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 10
) (
    // Clock
    input wire logic clk,
    // Access port
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    // ========================================================
    // Storage
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Write through the port, read data always registered
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : serial_port_memory

// ==== verif/serial_port_sva.sv ====
// Concurrent checks on the pointer driven serial port
`timescale 1ns/1ps
`include "serial_port_consts.svh"
module serial_port_sva #(
    parameter int ADDR_W = 10,
    parameter bit HIGH_PERF = 1'b0,
    parameter logic [15:0] RX_BAUD_MAX = 16'h2580,
    parameter int TICK_CYCLES = 400000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Command
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic cmd_transmit,
    input wire logic [15:0] cmd_baud,
    input wire logic [31:0] cmd_count,
    input wire logic [ADDR_W-1:0] cmd_pointer,
    input wire logic [15:0] cmd_timeout,
    // Status
    input wire logic busy,
    input wire logic done,
    input wire logic done_timeout,
    input wire logic cmd_error,
    input wire logic [ADDR_W-1:0] done_pointer,
    // Configuration and lines
    input wire logic config_we,
    input wire logic [7:0] config_data,
    input wire logic [7:0] config_byte,
    input wire logic txd_main,
    input wire logic txd_alt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic take, baud_ok;
    logic [15:0] hi_lim;
    logic tx_mode_reg, tx_mode_next;
    logic [ADDR_W-1:0] end_ptr_reg, end_ptr_next;
    logic [31:0] age_reg, age_next, lim_reg, lim_next;
    // ============================================================
    // Command capture, held after the take
    always_comb begin
        take = cmd_valid && cmd_ready;
        hi_lim = HIGH_PERF ? `BAUD_MAX_HP :
            (cmd_transmit ? `TX_BAUD_MAX_STD : RX_BAUD_MAX);
        baud_ok = cmd_baud >= `BAUD_MIN && cmd_baud <= hi_lim;
        tx_mode_next = tx_mode_reg;
        end_ptr_next = end_ptr_reg;
        lim_next = lim_reg;
        age_next = age_reg + 32'h1;
        if (take && baud_ok) begin
            tx_mode_next = cmd_transmit;
            end_ptr_next = cmd_pointer + cmd_count[ADDR_W-1:0];
            lim_next = TICK_CYCLES * ((cmd_timeout == 16'h0000) ?
                32'h1 : 32'(cmd_timeout));
            age_next = 32'h0;
        end
    end
    // Registers only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_mode_reg <= 1'b1;
            end_ptr_reg <= '0;
            lim_reg <= 32'h0;
            age_reg <= 32'h0;
        end else begin
            tx_mode_reg <= tx_mode_next;
            end_ptr_reg <= end_ptr_next;
            lim_reg <= lim_next;
            age_reg <= age_next;
        end
    end
    // ============================================================
    // Properties
    chk_idle_lines_high: assert property (
        cmd_ready && $past(cmd_ready) |-> txd_main && txd_alt)
        else $error("lines not idle high");
    chk_reroute_main: assert property (
        config_byte[4] && $past(config_byte[4]) |-> txd_main)
        else $error("main pin not idle");
    chk_unrouted_alt: assert property (
        !config_byte[4] && !$past(config_byte[4]) |-> txd_alt)
        else $error("alt pin not idle");
    chk_config_write: assert property (
        config_we |=> config_byte == $past(config_data))
        else $error("config not written");
    chk_zero_count: assert property (
        take && baud_ok && cmd_count == 32'h0 |-> ##2 done)
        else $error("zero count not done");
    chk_bad_baud: assert property (
        take && !baud_ok |=> cmd_error && !done)
        else $error("bad baud not refused");
    // The pointer lands one cycle ahead of the done pulse
    chk_tx_ptr_hold: assert property (
        tx_mode_reg && busy && $past(busy)
        |-> $stable(done_pointer) or ##1 done)
        else $error("tx pointer moved early");
    chk_tx_ptr_end: assert property (
        done && tx_mode_reg |-> done_pointer == end_ptr_reg)
        else $error("wrong tx pointer");
    chk_rx_ptr_step: assert property (
        !tx_mode_reg && busy && $past(busy)
        |-> ADDR_W'(done_pointer - $past(done_pointer)) <= 1)
        else $error("rx pointer step");
    chk_rx_time_cap: assert property (
        !tx_mode_reg && busy |-> age_reg <= lim_reg + 32'h4)
        else $error("rx timeout overrun");
    chk_timeout_late: assert property (
        done && done_timeout |-> age_reg + 32'h2 >= lim_reg)
        else $error("timeout early");
    chk_done_frees: assert property (
        done |=> cmd_ready)
        else $error("not ready after done");
    // Main scenarios reached
    cov_tx_done: cover property (done && tx_mode_reg);
    cov_rx_timeout: cover property (done && done_timeout);
    cov_refused: cover property (cmd_error);
    cov_rerouted: cover property (config_byte[4] && !txd_alt);
endmodule : serial_port_sva

// ==== verif/serial_far_end.sv ====
// Far end serial device model: drives rxd, decodes the transmit line
`timescale 1ns/1ps
module serial_far_end #(
    parameter int BAUD = 38400
) (
    // Serial lines
    input wire logic line_in,
    output logic line_out,
    // Decoded byte
    output logic [7:0] got_byte,
    output logic got_valid
);
    localparam real BIT_NS = 1.0e9 / BAUD;
    // ============================================================
    // Sender; marking level high between frames
    initial begin
        line_out = 1'b1;
        got_byte = 8'h00;
        got_valid = 1'b0;
    end
    task send_byte(input logic [7:0] b);
        line_out = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            line_out = b[i];
            #(BIT_NS);
        end
        line_out = 1'b1;
        #(BIT_NS);
    endtask : send_byte
    // ============================================================
    // Receiver; mid bit sampling, a bad stop bit spoils the byte
    always begin
        @(negedge line_in);
        #(BIT_NS * 1.5);
        for (int i = 0; i < 8; i++) begin
            got_byte[i] = line_in;
            #(BIT_NS);
        end
        if (line_in !== 1'b1) got_byte = 8'hxx;
        got_valid = 1'b1;
        #1;
        got_valid = 1'b0;
    end
endmodule : serial_far_end

// ==== verif/pointer_driven_serial_port_bench.sv ====
// Self-checking bench for the pointer driven serial port
`timescale 1ns/1ps
`include "serial_port_consts.svh"
module pointer_driven_serial_port_bench;
    localparam int AW = 10;
    logic mclk = 1'b0;
    logic resetn, cmd_valid, cmd_ready, cmd_transmit, busy, done;
    logic done_timeout, cmd_error, config_we, rxd, txd_main, txd_alt;
    logic host_we, got_valid;
    logic [15:0] cmd_baud, cmd_timeout;
    logic [31:0] cmd_count;
    logic [AW-1:0] cmd_pointer, done_pointer, host_addr;
    logic [7:0] config_data, config_byte, host_wdata, host_rdata;
    logic [7:0] got_byte, rd;
    logic [7:0] d[6];
    logic [15:0] bauds[4];
    logic [AW+1:0] last;
    logic [AW+1:0] notes[$]; // Error, timeout, pointer
    logic [7:0] tx_exp[$];
    int miscompares = 0;
    int checked = 0;
    always #12.5 mclk = ~mclk;
    pointer_driven_serial_port #(.ADDR_W(AW), .HIGH_PERF(1'b1),
        .TICK_CYCLES(20)) DUT (.*);
    // Unused pin idles high, so the AND is the selected transmit pin
    serial_far_end #(.BAUD(38400)) far (.line_in(txd_main & txd_alt),
        .line_out(rxd), .got_byte(got_byte), .got_valid(got_valid));
    // ============================================================
    // Compare and report
    task automatic check_note(input logic [AW+1:0] g, e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t status %h expected %h", $time, g, e);
        end
    endtask : check_note
    task automatic check_byte(input logic [7:0] g, e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
        end
    endtask : check_byte
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // ============================================================
    // Drivers; requests held until the edge that takes them
    task automatic issue(input logic tx, input logic [15:0] baud,
        input logic [31:0] cnt, input logic [AW-1:0] ptr,
        input logic [15:0] tmo, input logic [AW+1:0] note);
        notes.push_back(note);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_transmit <= tx;
        cmd_baud <= baud;
        cmd_count <= cnt;
        cmd_pointer <= ptr;
        cmd_timeout <= tmo;
        do @(posedge mclk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask : issue
    task automatic wait_idle();
        @(posedge mclk);
        for (int i = 0; i < 60000 && cmd_ready !== 1'b1; i++) @(posedge mclk);
    endtask : wait_idle
    task automatic mem_write(input logic [AW-1:0] a, input logic [7:0] v);
        @(posedge mclk);
        host_we <= 1'b1;
        host_addr <= a;
        host_wdata <= v;
    endtask : mem_write
    task automatic mem_read(input logic [AW-1:0] a, output logic [7:0] v);
        @(posedge mclk);
        host_addr <= a;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        v = host_rdata;
    endtask : mem_read
    task automatic set_config(input logic [7:0] v);
        @(posedge mclk);
        config_we <= 1'b1;
        config_data <= v;
        @(posedge mclk);
        config_we <= 1'b0;
    endtask : set_config
    // ============================================================
    // Result watchers take the oldest note off each queue
    always @(negedge mclk) begin
        if (done === 1'b1 || cmd_error === 1'b1) begin
            if (notes.size() == 0) check_note('0, 'x);
            else check_note({cmd_error, done_timeout, done_pointer},
                notes.pop_front());
        end
    end
    always @(posedge got_valid) begin
        if (tx_exp.size() == 0) check_byte(got_byte, 8'hxx);
        else check_byte(got_byte, tx_exp.pop_front());
    end
    // Watchdog; the tests need roughly 70k cycles
    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        print_verdict();
    end
    // ============================================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        {cmd_valid, cmd_transmit, config_we, host_we} = 4'h0;
        {cmd_baud, cmd_timeout, cmd_count} = '0;
        {cmd_pointer, host_addr, config_data, host_wdata} = '0;
        bauds = '{`BAUD_MIN - 16'h1, `BAUD_MIN, `BAUD_MAX_HP,
            `BAUD_MAX_HP + 16'h1};
        void'($urandom(26));
        foreach (d[i]) d[i] = 8'($urandom);
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        check_byte(config_byte, `CFG_RESET);
        check_byte({6'h00, txd_main, txd_alt}, 8'h03);
        // Transmit across the address wrap
        mem_write(10'h3ff, d[0]);
        mem_write(10'h000, d[1]);
        mem_write(10'h001, d[2]);
        @(posedge mclk);
        host_we <= 1'b0;
        tx_exp = '{d[0], d[1]};
        issue(1'b1, `BAUD_MAX_HP, 2, 10'h3ff, 0, {2'b00, 10'h001});
        wait_idle();
        // Rerouted transmit of one byte
        set_config(8'h10);
        tx_exp.push_back(d[2]);
        issue(1'b1, `BAUD_MAX_HP, 1, 10'h001, 0, {2'b00, 10'h002});
        wait_idle();
        set_config(8'h00);
        // Baud limits in both directions, zero count
        last = {2'b00, 10'h002};
        for (int i = 0; i < 8; i++) begin
            if (i % 4 == 1 || i % 4 == 2) last = {2'b00, AW'(i)};
            issue(i[2], bauds[i % 4], 0, AW'(i), 1,
                (i % 4 == 1 || i % 4 == 2) ? last : {1'b1, last[AW:0]});
            wait_idle();
        end
        // Receive two bytes ahead of a long timeout
        issue(1'b0, `BAUD_MAX_HP, 2, 10'h200, 5000, {2'b00, 10'h202});
        far.send_byte(d[3]);
        far.send_byte(d[4]);
        wait_idle();
        mem_read(10'h200, rd);
        check_byte(rd, d[3]);
        mem_read(10'h201, rd);
        check_byte(rd, d[4]);
        // One byte of three, then timeout
        issue(1'b0, `BAUD_MAX_HP, 3, 10'h300, 700, {2'b01, 10'h301});
        far.send_byte(d[5]);
        wait_idle();
        mem_read(10'h300, rd);
        check_byte(rd, d[5]);
        // Silent line, zero timeout served as one tick
        issue(1'b0, `BAUD_MAX_HP, 2, 10'h3fe, 0, {2'b01, 10'h3fe});
        wait_idle();
        repeat (4) @(posedge mclk);
        check_byte(8'(notes.size() + tx_exp.size()), 8'h00);
        print_verdict();
    end
endmodule : pointer_driven_serial_port_bench
bind pointer_driven_serial_port serial_port_sva #(.ADDR_W(ADDR_W),
    .HIGH_PERF(HIGH_PERF), .RX_BAUD_MAX(RX_BAUD_MAX),
    .TICK_CYCLES(TICK_CYCLES)) u_sva (.*);
